// ==== verilog/dbat_host.sv ====
/*
  Host controller end: software posts one command at a time over
  AHB-Lite; the controller holds it until every core interval is met,
  then sends its beats on the link, clocking CK by a divider.
  Assumes a single AHB-Lite master and a fixed link clock rate.
*/
// Implementation choice: register access over AHB-Lite.
`timescale 1ns/1ps
// Summary of operation
// [R1] Pattern B resets to 3C, mode-write replaces
// [R2] Calibration sends pattern A then B everywhere
// [R3] Pattern bits leave least significant first
// [R4] Lanes invert per register; DMI never inverted
// [R5] DMI silent when read inversion disabled
// [R6] No bus-inversion coding during calibration
// [R7] Activate is two beats: CA1 low, then high
// [R8] Bank from three bits, row from beats
// [R9] Column access only after tRCD from activate
// [R10] Precharge before reactivating; honour tRAS, tRP
// [R11] Same-bank activates spaced by tRC
// [R12] Different-bank activates spaced by tRRD
// [R13] At most four activates per tFAW window
// [R14] Window clocks are tFAW over tCK, rounded up
// [R15] All-bank precharge waits the longer tRPab
// [R16] Flag banks open beyond the longest row time
// [R17] Read to precharge waits tRTP
// [R18] Self-refresh exit waits tXSR
// [R19] Power-down exit waits tXP
// [R20] Self-refresh lasts at least tSR
// [R21] Precharges spaced by four clocks
// [R22] Auto-precharge exempt from precharge spacing
// [R23] Column commands spaced eight clocks; tWR, tWTR
// [R24] Track per-bank state and timestamps
module dbat_host import dbat_pkg::*; #(
  parameter int CK_DIV = 16,
  parameter int AGE_W = 12,
  parameter int T_RFCAB_PS = 280000
) (
  input wire logic MCLK,
  input wire logic NRST,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  dbat_if.host LNK
);
  localparam int HALF = CK_DIV / 2;
  localparam int TCK_PS = MCLK_PS * CK_DIV;
  typedef logic [AGE_W-1:0] age_t;
  localparam age_t A_RCD = AGE_W'(dbat_ncyc(T_RCD_PS, NCK_RCD, TCK_PS));
  localparam age_t A_RPPB = AGE_W'(dbat_ncyc(T_RPPB_PS, NCK_RPPB, TCK_PS));
  localparam age_t A_RPAB = AGE_W'(dbat_ncyc(T_RPAB_PS, NCK_RPAB, TCK_PS));
  localparam age_t A_RAS = AGE_W'(dbat_ncyc(T_RAS_PS, NCK_RAS, TCK_PS));
  localparam age_t A_RC = A_RAS + A_RPPB;
  localparam age_t A_RRD = AGE_W'(dbat_ncyc(T_RRD_PS, NCK_RRD, TCK_PS));
  localparam age_t A_FAW = AGE_W'(dbat_ncyc(T_FAW_PS, 1, TCK_PS)); // R14
  localparam age_t A_RTP = AGE_W'(dbat_ncyc(T_RTP_PS, NCK_RTP, TCK_PS));
  localparam age_t A_WR = AGE_W'(dbat_ncyc(T_WR_PS, NCK_WR, TCK_PS));
  localparam age_t A_WTR = AGE_W'(dbat_ncyc(T_WTR_PS, NCK_WTR, TCK_PS));
  localparam age_t A_CCD = AGE_W'(NCK_CCD);
  localparam age_t A_PPD = AGE_W'(NCK_PPD);
  localparam age_t A_XP = AGE_W'(dbat_ncyc(T_XP_PS, NCK_XP, TCK_PS));
  localparam age_t A_XSR = AGE_W'(dbat_ncyc(T_RFCAB_PS + T_XSR_PS, NCK_XSR, TCK_PS));
  localparam age_t A_SR = AGE_W'(dbat_ncyc(T_SR_PS, NCK_SR, TCK_PS));
  localparam age_t A_RASMAX = AGE_W'(T_RASMAX_PS / TCK_PS);

  logic [7:0] div_reg;
  logic ck_reg, cs_reg;
  logic [CA_W-1:0] ca_reg;
  logic [31:0] cmd_reg;
  logic pend_reg, sr_reg, pd_reg, ap_wr_reg;
  logic [7:0] ap_addr_reg;
  logic [(MAX_BEATS-1)*CA_W-1:0] beat_sr_reg, beat_rest;
  logic [2:0] left_reg, nbeats;
  logic [CA_W-1:0] beat0;
  logic [NBANK-1:0] open_reg;
  age_t act_age [NBANK];
  age_t pre_age [NBANK];
  age_t rd_age [NBANK];
  age_t wr_age [NBANK];
  age_t faw_age [FAW_DEPTH];
  age_t act_g, pre_g, prea_g, cas_g, wr_g, x_age, x_need_reg, sre_age;
  logic ok;

  function automatic age_t inc(age_t a);
    return (a == '1) ? a : a + age_t'(1);
  endfunction : inc
  // Link clock divider; commands change on its falling edge
  wire div_end = div_reg == 8'(HALF - 1);
  wire tick = div_end && ck_reg;
  wire busy = pend_reg || left_reg != 3'h0;
  wire dbat_op_t op = dbat_op_t'(cmd_reg[CMD_OP_LSB +: 4]);
  wire [BA_W-1:0] ba = cmd_reg[CMD_BA_LSB +: BA_W];
  wire [ROW_W-1:0] row = cmd_reg[CMD_ROW_LSB +: ROW_W];
  wire [PAT_W-1:0] mdat = cmd_reg[CMD_DAT_LSB +: PAT_W];
  wire [MA_W-1:0] ma = cmd_reg[CMD_MA_LSB +: MA_W];
  wire [NBANK-1:0] bsel = NBANK'(1) << ba;
  wire issue = tick && left_reg == 3'h0 && pend_reg && ok;
  wire is_act = issue && op == OP_ACT;
  wire act_like = issue && (op == OP_ACT || op == OP_PER_BANK_REFRESH); // R13
  wire is_pre = issue && op == OP_PRE;
  wire is_prea = issue && op == OP_PREA;
  wire is_rd = issue && op == OP_RD;
  wire is_wr = issue && op == OP_WR;
  wire [NBANK-1:0] pre_ok, over;
  wire faw_ok = faw_age[FAW_DEPTH-1] >= A_FAW; // R13
  wire exit_ok = x_age >= x_need_reg && !sr_reg && !pd_reg; // R18 R19

  // Per-bank state and timestamps
  for (genvar b = 0; b < NBANK; b++) begin : g_bank
    assign pre_ok[b] = act_age[b] >= A_RAS && rd_age[b] >= A_RTP
                       && wr_age[b] >= A_WR; // R10 R17 R23
    assign over[b] = open_reg[b] && act_age[b] >= A_RASMAX; // R16
    always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
        act_age[b] <= '1;
        pre_age[b] <= '1;
        rd_age[b] <= '1;
        wr_age[b] <= '1;
        open_reg[b] <= 1'b0;
      end else if (tick) begin
        act_age[b] <= (act_like && bsel[b]) ? '0 : inc(act_age[b]); // R24
        pre_age[b] <= ((is_pre && bsel[b]) || is_prea) ? '0 : inc(pre_age[b]);
        rd_age[b] <= (is_rd && bsel[b]) ? '0 : inc(rd_age[b]);
        wr_age[b] <= (is_wr && bsel[b]) ? '0 : inc(wr_age[b]);
        if (is_act && bsel[b]) open_reg[b] <= 1'b1;
        else if ((is_pre && bsel[b]) || is_prea) open_reg[b] <= 1'b0;
      end
    end
  end

  for (genvar i = 0; i < FAW_DEPTH; i++) begin : g_faw
    always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) faw_age[i] <= '1;
      else if (tick && act_like)
        faw_age[i] <= (i == 0) ? '0 : inc(faw_age[(i + FAW_DEPTH - 1) % FAW_DEPTH]);
      else if (tick) faw_age[i] <= inc(faw_age[i]);
    end
  end

  always_comb begin
    case (op)
      OP_ACT, OP_PER_BANK_REFRESH: ok = !open_reg[ba] && pre_age[ba] >= A_RPPB // R10
                             && prea_g >= A_RPAB && act_age[ba] >= A_RC // R11 R15
                             && act_g >= A_RRD && faw_ok && exit_ok; // R12 R13
      OP_RD: ok = open_reg[ba] && act_age[ba] >= A_RCD && cas_g >= A_CCD // R9 R23
                  && wr_g >= A_WTR && exit_ok; // R23
      OP_WR: ok = open_reg[ba] && act_age[ba] >= A_RCD && cas_g >= A_CCD // R9
                  && exit_ok;
      // No auto-precharge is sent, so every precharge is spaced
      OP_PRE: ok = pre_ok[ba] && pre_g >= A_PPD && exit_ok; // R21 R22
      OP_PREA: ok = &pre_ok && pre_g >= A_PPD && exit_ok; // R21
      OP_SRE: ok = open_reg == 8'h00 && exit_ok;
      OP_SRX: ok = sr_reg && sre_age >= A_SR; // R20
      OP_PDX: ok = pd_reg;
      default: ok = exit_ok;
    endcase
  end

  // Beat patterns; activate carries bank and row over two beats
  always_comb begin
    beat_rest = '0;
    if (op == OP_ACT) begin
      beat0 = {row[ROW_W-1], ba, CA_ACT1}; // R7
      beat_rest[CA_W-1:0] = {row[ROW_W-2:0], CA_ACT2}; // R7
      nbeats = 3'h2;
    end else if (op == OP_MRW) begin
      beat0 = {op, CA_OTH};
      beat_rest = {2'h0, mdat[PAT_W-1:NIB_W], 2'h0, mdat[NIB_W-1:0], ma};
      nbeats = 3'h4;
    end else begin
      beat0 = {op, CA_OTH};
      beat_rest[CA_W-1:0] = {3'h0, ba};
      nbeats = 3'h2;
    end
  end

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      div_reg <= 8'h00;
      ck_reg <= 1'b0;
    end else begin
      div_reg <= div_end ? 8'h00 : div_reg + 8'h01;
      if (div_end) ck_reg <= ~ck_reg;
    end
  end

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      cs_reg <= 1'b0;
      ca_reg <= 6'h00;
      beat_sr_reg <= '0;
      left_reg <= 3'h0;
    end else if (tick) begin
      if (left_reg != 3'h0) begin
        cs_reg <= 1'b1;
        ca_reg <= beat_sr_reg[CA_W-1:0];
        beat_sr_reg <= beat_sr_reg >> CA_W;
        left_reg <= left_reg - 3'h1;
      end else if (issue) begin
        cs_reg <= 1'b1;
        ca_reg <= beat0;
        beat_sr_reg <= beat_rest;
        left_reg <= nbeats - 3'h1;
      end else begin
        cs_reg <= 1'b0;
        ca_reg <= 6'h00;
      end
    end
  end

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      act_g <= '1;
      pre_g <= '1;
      prea_g <= '1;
      cas_g <= '1;
      wr_g <= '1;
      x_age <= '1;
      x_need_reg <= '0;
      sre_age <= '0;
      sr_reg <= 1'b0;
      pd_reg <= 1'b0;
    end else if (tick) begin
      act_g <= act_like ? '0 : inc(act_g); // R12
      pre_g <= (is_pre || is_prea) ? '0 : inc(pre_g);
      prea_g <= is_prea ? '0 : inc(prea_g); // R15
      cas_g <= (is_rd || is_wr) ? '0 : inc(cas_g);
      wr_g <= is_wr ? '0 : inc(wr_g);
      x_age <= (issue && (op == OP_SRX || op == OP_PDX)) ? '0 : inc(x_age);
      if (issue && op == OP_SRX) x_need_reg <= A_XSR; // R18
      else if (issue && op == OP_PDX) x_need_reg <= A_XP; // R19
      sre_age <= (issue && op == OP_SRE) ? '0 : inc(sre_age);
      if (issue && op == OP_SRE) sr_reg <= 1'b1;
      else if (issue && op == OP_SRX) sr_reg <= 1'b0;
      if (issue && op == OP_PDE) pd_reg <= 1'b1;
      else if (issue && op == OP_PDX) pd_reg <= 1'b0;
    end
  end

  // AHB-Lite slave, zero wait states
  wire ap_take = HSEL && HREADY && HTRANS == HTRANS_NONSEQ;
  wire cmd_we = ap_wr_reg && ap_addr_reg == REG_CMD && !busy;
  wire [7:0] raddr = HADDR[7:0];
  wire [31:0] stat = {6'h00, pd_reg, sr_reg, over, open_reg, 7'h00, busy};
  wire [31:0] rd_mux = (raddr == REG_CMD) ? cmd_reg : (raddr == REG_STAT) ? stat : 32'h0;

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      ap_wr_reg <= 1'b0;
      ap_addr_reg <= 8'h00;
      cmd_reg <= 32'h00000000;
      pend_reg <= 1'b0;
      HRDATA <= 32'h00000000;
      HREADYOUT <= 1'b1;
      HRESP <= HRESP_OKAY;
    end else begin
      if (HREADY) ap_wr_reg <= ap_take && HWRITE;
      if (HREADY) ap_addr_reg <= HADDR[7:0];
      if (cmd_we) cmd_reg <= HWDATA;
      if (cmd_we) pend_reg <= 1'b1;
      else if (issue) pend_reg <= 1'b0;
      HRDATA <= (ap_take && !HWRITE) ? rd_mux : 32'h00000000;
    end
  end

  assign LNK.ck = ck_reg;
  assign LNK.cs = cs_reg;
  assign LNK.ca = ca_reg;
endmodule : dbat_host

// ==== verilog/dbat_pkg.sv ====
/*
  Shared constants for the DRAM bank-activation link: command encodings,
  mode-register addresses and reset values, core timing minima, and the
  host's own register map.
  Assumes a 200 MHz system clock on both ends.
*/
package dbat_pkg;
  localparam int NBANK = 8;
  localparam int BA_W = 3;
  localparam int ROW_W = 5;
  localparam int CA_W = 6;
  localparam int DQ_W = 16;
  localparam int DMI_W = 2;
  localparam int MA_W = 6;
  localparam int PAT_W = 8;
  localparam int NIB_W = 4;
  localparam int CAL_BITS = 2 * PAT_W;
  localparam int FAW_DEPTH = 4;
  localparam int MAX_BEATS = 4;

  // Low two CA bits tag both activate beats and the first beat of other commands
  localparam logic [1:0] CA_ACT1 = 2'h1;
  localparam logic [1:0] CA_ACT2 = 2'h3;
  localparam logic [1:0] CA_OTH = 2'h0;

  typedef enum logic [3:0] {
    OP_NOP = 4'h0, OP_RD = 4'h1, OP_WR = 4'h2, OP_PRE = 4'h3,
    OP_PREA = 4'h4, OP_MRW = 4'h5, OP_CAL = 4'h6, OP_SRE = 4'h7,
    OP_SRX = 4'h8, OP_PDE = 4'h9, OP_PDX = 4'hA, OP_PER_BANK_REFRESH = 4'hB,
    OP_ACT = 4'hC
  } dbat_op_t;

  localparam logic [MA_W-1:0] MA_CFG = 6'h03;
  localparam logic [MA_W-1:0] MA_INV_LO = 6'h0F;
  localparam logic [MA_W-1:0] MA_INV_HI = 6'h14;
  localparam logic [MA_W-1:0] MA_PAT_A = 6'h20;
  localparam logic [MA_W-1:0] MA_PAT_B = 6'h28;
  localparam logic [PAT_W-1:0] PAT_A_RST = 8'h5A;
  localparam logic [PAT_W-1:0] PAT_B_RST = 8'h3C;
  localparam int CFG_RDBI_BIT = 6;

  localparam int MCLK_PS = 5000;
  localparam int T_RCD_PS = 18000;
  localparam int NCK_RCD = 4;
  localparam int T_RPPB_PS = 18000;
  localparam int NCK_RPPB = 4;
  localparam int T_RPAB_PS = 21000;
  localparam int NCK_RPAB = 4;
  localparam int T_RAS_PS = 42000;
  localparam int NCK_RAS = 3;
  localparam int T_RASMAX_PS = 70200000;
  localparam int T_RRD_PS = 10000;
  localparam int NCK_RRD = 4;
  localparam int T_FAW_PS = 40000;
  localparam int T_RTP_PS = 7500;
  localparam int NCK_RTP = 8;
  localparam int T_WR_PS = 18000;
  localparam int NCK_WR = 6;
  localparam int T_WTR_PS = 10000;
  localparam int NCK_WTR = 8;
  localparam int NCK_CCD = 8;
  localparam int NCK_PPD = 4;
  localparam int T_XP_PS = 7500;
  localparam int NCK_XP = 5;
  localparam int T_XSR_PS = 7500;
  localparam int NCK_XSR = 2;
  localparam int T_SR_PS = 15000;
  localparam int NCK_SR = 3;

  // Host register map and field layout
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_BA_LSB = 4;
  localparam int CMD_ROW_LSB = 7;
  localparam int CMD_DAT_LSB = 12;
  localparam int CMD_MA_LSB = 20;
  localparam int ST_BUSY = 0;
  localparam int ST_OPEN_LSB = 8;
  localparam int ST_OVER_LSB = 16;
  localparam int ST_SR = 24;
  localparam int ST_PD = 25;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;

  // Least time in clocks: round up, never below the clock minimum
  function automatic int dbat_ncyc(int t_ps, int n_ck, int tck_ps);
    int c;
    c = (t_ps + tck_ps - 1) / tck_ps;
    return (c > n_ck) ? c : n_ck;
  endfunction : dbat_ncyc
endpackage : dbat_pkg

// ==== verilog/dbat_if.sv ====
/*
  Command/address link between host controller and DRAM device.
  Assumes the bench resolves the DQ and DMI wires from the enables.
*/
`timescale 1ns/1ps
interface dbat_if;
  import dbat_pkg::*;
  logic ck;
  logic cs;
  logic [CA_W-1:0] ca;
  logic [DQ_W-1:0] dq_o;
  logic dq_oe;
  logic [DMI_W-1:0] dmi_o;
  logic dmi_oe;
  modport dev(input ck, input cs, input ca,
              output dq_o, output dq_oe, output dmi_o, output dmi_oe);
  modport host(output ck, output cs, output ca);
endinterface : dbat_if

// ==== verilog/dbat_dev.sv ====
/*
  DRAM device end: decodes two- and four-beat commands on link clock rises, tracks
  open banks, holds calibration and inversion mode registers, and
  returns the calibration pattern on DQ and DMI.
  Assumes CK, CS and CA come from another domain; the host keeps timing.
*/
`timescale 1ns/1ps
module dbat_dev import dbat_pkg::*; (
  input wire logic MCLK,
  input wire logic NRST,
  dbat_if.dev LNK,
  output logic [NBANK-1:0] BANK_OPEN,
  output logic [BA_W-1:0] LAST_BANK,
  output logic [ROW_W-1:0] LAST_ROW,
  output logic CAL_BUSY
);
  typedef enum logic [2:0] {
    D_IDLE = 3'b000, D_ACT2 = 3'b001, D_ARG = 3'b010,
    D_MLO = 3'b011, D_MHI = 3'b100, D_CAL = 3'b101
  } dbat_dst_t;

  logic [2:0] ck_s_reg, cs_s_reg;
  logic [CA_W-1:0] ca1_reg, ca2_reg, ca3_reg;
  logic ck_lvl_reg;
  dbat_dst_t st_reg, st_next;
  dbat_op_t op_reg;
  logic [BA_W-1:0] ba_reg;
  logic rowhi_reg;
  logic [MA_W-1:0] ma_reg;
  logic [NIB_W-1:0] lo_reg;
  logic [4:0] bit_reg;
  logic [PAT_W-1:0] pat_a_reg, pat_b_reg, inv_lo_reg, inv_hi_reg, cfg_reg;
  logic [DQ_W-1:0] dq_reg;
  logic [DMI_W-1:0] dmi_reg;
  logic dq_oe_reg, dmi_oe_reg;

  // Edge found once second and third stages agree
  wire agree = ck_s_reg[1] == ck_s_reg[2];
  wire rise = agree && ck_s_reg[2] && !ck_lvl_reg;
  wire cs = cs_s_reg[2];
  wire [CA_W-1:0] ca = ca3_reg;
  wire act1 = rise && st_reg == D_IDLE && cs && ca[1:0] == CA_ACT1; // R7
  wire act2 = rise && st_reg == D_ACT2 && cs && ca[1:0] == CA_ACT2; // R7
  wire arg = rise && st_reg == D_ARG && cs;
  wire mrw_done = rise && st_reg == D_MHI && cs;
  wire [PAT_W-1:0] mr_data = {ca[NIB_W-1:0], lo_reg};
  wire wr_pa = mrw_done && ma_reg == MA_PAT_A;
  wire wr_pb = mrw_done && ma_reg == MA_PAT_B;
  wire wr_il = mrw_done && ma_reg == MA_INV_LO;
  wire wr_ih = mrw_done && ma_reg == MA_INV_HI;
  wire wr_cf = mrw_done && ma_reg == MA_CFG;
  wire [NBANK-1:0] bsel = NBANK'(1) << ca[BA_W-1:0];
  wire [NBANK-1:0] asel = NBANK'(1) << ba_reg;
  wire pre_one = arg && op_reg == OP_PRE;
  wire pre_all = arg && op_reg == OP_PREA;
  wire cal_run = rise && st_reg == D_CAL && bit_reg != 5'(CAL_BITS);
  wire cal_end = rise && st_reg == D_CAL && bit_reg == 5'(CAL_BITS);
  wire [2*PAT_W-1:0] pat = {pat_b_reg, pat_a_reg}; // R2
  wire cal_bit = pat[bit_reg[3:0]]; // R3
  // Per-lane inversion only; no bus-inversion encoding here
  wire [DQ_W-1:0] dq_next = {DQ_W{cal_bit}} ^ {inv_hi_reg, inv_lo_reg}; // R4 R6

  always_comb begin
    st_next = st_reg;
    if (rise) begin
      case (st_reg)
        D_IDLE: begin
          if (act1) st_next = D_ACT2;
          else if (cs && ca[1:0] == CA_OTH) st_next = D_ARG;
        end
        D_ACT2: st_next = D_IDLE;
        D_ARG: begin
          if (cs && op_reg == OP_MRW) st_next = D_MLO;
          else if (cs && op_reg == OP_CAL) st_next = D_CAL;
          else st_next = D_IDLE;
        end
        D_MLO: st_next = cs ? D_MHI : D_IDLE;
        D_MHI: st_next = D_IDLE;
        D_CAL: if (cal_end) st_next = D_IDLE;
        default: st_next = D_IDLE;
      endcase
    end
  end

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      ck_s_reg <= 3'h0;
      cs_s_reg <= 3'h0;
      ca1_reg <= 6'h00;
      ca2_reg <= 6'h00;
      ca3_reg <= 6'h00;
      ck_lvl_reg <= 1'b0;
    end else begin
      ck_s_reg <= {ck_s_reg[1:0], LNK.ck};
      cs_s_reg <= {cs_s_reg[1:0], LNK.cs};
      ca1_reg <= LNK.ca;
      ca2_reg <= ca1_reg;
      ca3_reg <= ca2_reg;
      if (agree) ck_lvl_reg <= ck_s_reg[2];
    end
  end

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      st_reg <= D_IDLE;
      op_reg <= OP_NOP;
      ba_reg <= 3'h0;
      rowhi_reg <= 1'b0;
      ma_reg <= 6'h00;
      lo_reg <= 4'h0;
      bit_reg <= 5'h00;
    end else begin
      st_reg <= st_next;
      if (rise && st_reg == D_IDLE) op_reg <= dbat_op_t'(ca[CA_W-1:2]);
      if (act1) ba_reg <= ca[4:2]; // R8
      if (act1) rowhi_reg <= ca[5];
      if (arg) ma_reg <= ca;
      if (rise && st_reg == D_MLO) lo_reg <= ca[NIB_W-1:0];
      if (arg) bit_reg <= 5'h00;
      else if (cal_run) bit_reg <= bit_reg + 5'h01;
    end
  end

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      pat_a_reg <= PAT_A_RST;
      pat_b_reg <= PAT_B_RST; // R1
      inv_lo_reg <= 8'h00;
      inv_hi_reg <= 8'h00;
      cfg_reg <= 8'h00;
    end else begin
      if (wr_pa) pat_a_reg <= mr_data;
      if (wr_pb) pat_b_reg <= mr_data; // R1
      if (wr_il) inv_lo_reg <= mr_data;
      if (wr_ih) inv_hi_reg <= mr_data;
      if (wr_cf) cfg_reg <= mr_data;
    end
  end

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      BANK_OPEN <= 8'h00;
      LAST_BANK <= 3'h0;
      LAST_ROW <= 5'h00;
      CAL_BUSY <= 1'b0;
    end else begin
      if (act2) BANK_OPEN <= BANK_OPEN | asel; // R8
      else if (pre_all) BANK_OPEN <= 8'h00;
      else if (pre_one) BANK_OPEN <= BANK_OPEN & ~bsel;
      if (act2) LAST_BANK <= ba_reg;
      if (act2) LAST_ROW <= {rowhi_reg, ca[5:2]}; // R8
      CAL_BUSY <= st_next == D_CAL;
    end
  end

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      dq_reg <= 16'h0000;
      dmi_reg <= 2'h0;
      dq_oe_reg <= 1'b0;
      dmi_oe_reg <= 1'b0;
    end else if (cal_run) begin
      dq_reg <= dq_next;
      dmi_reg <= {DMI_W{cal_bit}}; // R4
      dq_oe_reg <= 1'b1;
      dmi_oe_reg <= cfg_reg[CFG_RDBI_BIT]; // R5
    end else if (cal_end) begin
      dq_oe_reg <= 1'b0;
      dmi_oe_reg <= 1'b0;
    end
  end

  assign LNK.dq_o = dq_reg;
  assign LNK.dq_oe = dq_oe_reg;
  assign LNK.dmi_o = dmi_reg;
  assign LNK.dmi_oe = dmi_oe_reg;
endmodule : dbat_dev

// ==== dv/dbat_properties.sv ====
/* Link checker: command framing, spacing and calibration output.
   Assumes MCLK samples the link signals between the two design ends. */
`timescale 1ns/1ps
module dbat_properties import dbat_pkg::*; #(
  parameter int CK_DIV = 8
) (
  input wire logic MCLK,
  input wire logic NRST,
  input wire logic ck,
  input wire logic cs,
  input wire logic [CA_W-1:0] ca,
  input wire logic [DQ_W-1:0] dq_o,
  input wire logic dq_oe,
  input wire logic [DMI_W-1:0] dmi_o,
  input wire logic dmi_oe
);
  localparam int CKP = CK_DIV;
  localparam int SP4 = 4 * CK_DIV;
  localparam int SP8 = 8 * CK_DIV;
  localparam int OE_LO = 16 * CK_DIV - 1;
  localparam int OE_HI = 16 * CK_DIV + 1;
  logic ck_reg;
  logic [1:0] beat_reg;
  logic [BA_W-1:0] act_ba_reg;
  logic [9:0] act_reg, col_reg, pre_reg, oe_reg;
  wire rise = ck & ~ck_reg;
  // First beat: no beat of a command still due
  wire first = rise & cs & (beat_reg == 2'h0);
  wire act1 = first & (ca[1:0] == CA_ACT1);
  wire cmd0 = first & (ca[1:0] == CA_OTH);
  wire [1:0] beats_due = (cmd0 && ca[5:2] == OP_MRW) ? 2'h3 : 2'h1;
  wire col = cmd0 & (ca[5:2] == OP_RD || ca[5:2] == OP_WR);
  wire pre = cmd0 & (ca[5:2] == OP_PRE || ca[5:2] == OP_PREA);
  function automatic logic [9:0] up(logic [9:0] v, logic clr);
    return clr ? 10'h000 : v + {9'h000, v != 10'h3FF};
  endfunction : up
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      ck_reg <= 1'b0;
      beat_reg <= 2'h0;
      act_ba_reg <= 3'h0;
      act_reg <= 10'h3FF;
      col_reg <= 10'h3FF;
      pre_reg <= 10'h3FF;
      oe_reg <= 10'h000;
    end else begin
      ck_reg <= ck;
      if (first) beat_reg <= beats_due;
      else if (rise && cs) beat_reg <= beat_reg - 2'h1;
      if (act1) act_ba_reg <= ca[4:2];
      act_reg <= up(act_reg, act1);
      col_reg <= up(col_reg, col);
      pre_reg <= up(pre_reg, pre);
      oe_reg <= up(oe_reg, ~dq_oe);
    end
  end
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!NRST);
  sequence s_act1;
    act1;
  endsequence
  sequence s_act2;
    rise && cs && beat_reg == 2'h1 && ca[1:0] == CA_ACT2;
  endsequence
  sequence s_col_same;
    col ##[CKP:CKP] rise && ca[BA_W-1:0] == act_ba_reg;
  endsequence
  act_pair_a: assert property (s_act1 |-> ##[CKP:CKP] s_act2)
    else $error("activate second beat missing");
  beat_hold_a: assert property (ck && $past(ck) |-> $stable(cs) && $stable(ca))
    else $error("beat changed while link clock high");
  act_space_a: assert property (act1 |-> act_reg >= SP4)
    else $error("activates too close");
  row_col_a: assert property (s_col_same |-> act_reg >= SP4 + CKP - 1)
    else $error("column command too soon after activate");
  col_space_a: assert property (col |-> col_reg >= SP8)
    else $error("column commands too close");
  pre_space_a: assert property (pre |-> pre_reg >= SP4)
    else $error("precharges too close");
  mask_lane_a: assert property (dmi_oe |-> dq_oe && dmi_o[0] == dmi_o[1])
    else $error("mask lanes driven outside calibration or unequal");
  cal_len_a: assert property ($fell(dq_oe) |-> oe_reg >= OE_LO && oe_reg <= OE_HI)
    else $error("calibration burst length wrong");
endmodule : dbat_properties

// ==== dv/testbench.sv ====
/* Bench: host and device joined by the link, driven over AHB-Lite.
   Assumes a 200 MHz MCLK and a link clock divider of 8. */
`timescale 1ns/1ps
module testbench import dbat_pkg::*; ;
  localparam int CKD = 8;
  logic mclk, nrst, hsel, hwrite, hreadyout, hresp, cal_busy, e_dmi;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [NBANK-1:0] bank_open;
  logic [BA_W-1:0] last_bank;
  logic [ROW_W-1:0] last_row;
  logic [15:0] e_pat, e_inv;
  int bad_count, checks;
  dbat_if lnk();
  dbat_host #(.CK_DIV(CKD)) i_dbat_host(.MCLK(mclk), .NRST(nrst), .HSEL(hsel),
    .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
    .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
    .LNK(lnk.host));
  dbat_dev i_dbat_dev(.MCLK(mclk), .NRST(nrst), .LNK(lnk.dev), .BANK_OPEN(bank_open),
    .LAST_BANK(last_bank), .LAST_ROW(last_row), .CAL_BUSY(cal_busy));
  dbat_properties #(.CK_DIV(CKD)) i_dbat_properties(.MCLK(mclk), .NRST(nrst),
    .ck(lnk.ck), .cs(lnk.cs), .ca(lnk.ca), .dq_o(lnk.dq_o), .dq_oe(lnk.dq_oe),
    .dmi_o(lnk.dmi_o), .dmi_oe(lnk.dmi_oe));
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      bad_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, s, e);
    end
  endtask : check
  task automatic give_verdict;
    $display("counts: %0d checks, %0d mismatches", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict
  task automatic guard(input logic ok);
    if (ok !== 1'b1) begin
      bad_count++;
      $display("mismatch at %0t: wait timed out", $time);
      give_verdict();
    end
  endtask : guard
  task automatic ready;
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    guard(hreadyout === 1'b1);
  endtask : ready
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= HTRANS_NONSEQ;
    ready();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    ready();
    q = hrdata;
  endtask : ahb
  // Samples each calibration bit mid-period
  task automatic grab;
    int n;
    n = 0;
    while (lnk.dq_oe !== 1'b1 && n < 500) begin
      @(posedge mclk);
      n++;
    end
    guard(lnk.dq_oe === 1'b1);
    repeat (CKD / 2) @(posedge mclk);
    check(cal_busy, 1'b1);
    for (int k = 0; k < CAL_BITS; k++) begin
      check(lnk.dq_o, {DQ_W{e_pat[k]}} ^ e_inv);
      check(lnk.dmi_oe, e_dmi);
      if (e_dmi) check(lnk.dmi_o, {DMI_W{e_pat[k]}});
      repeat (CKD) @(posedge mclk);
    end
    check(lnk.dq_oe, 1'b0);
  endtask : grab
  task automatic cmd(input logic [3:0] op, input logic [2:0] ba, input logic [4:0] row,
                     input logic [5:0] ma, input logic [7:0] dat);
    int n;
    ahb(1'b1, 32'h0, {6'h00, ma, dat, row, ba, op});
    if (op == OP_CAL) grab();
    n = 0;
    do begin
      ahb(1'b0, 32'h4, 32'h0);
      n++;
    end while (q[ST_BUSY] !== 1'b0 && n < 500);
    guard(q[ST_BUSY] === 1'b0);
  endtask : cmd
  task automatic stat(input logic [31:0] m, input logic [31:0] e);
    repeat (2 * CKD) @(posedge mclk);
    ahb(1'b0, 32'h4, 32'h0);
    check(q & m, e);
  endtask : stat
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  initial begin
    nrst = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    bad_count = 0;
    checks = 0;
    e_pat = 16'h3C5A;
    e_inv = 16'h0000;
    e_dmi = 1'b0;
    repeat (3) @(posedge mclk);
    nrst <= 1'b1;
    ahb(1'b0, 32'h8, 32'h0);
    check(q, 32'h0);
    check({hreadyout, hresp}, 2'h2);
    cmd(OP_CAL, 3'h0, 5'h00, 6'h00, 8'h00);
    cmd(OP_MRW, 3'h0, 5'h00, MA_PAT_B, 8'h27);
    cmd(OP_MRW, 3'h0, 5'h00, MA_INV_LO, 8'h01);
    cmd(OP_MRW, 3'h0, 5'h00, MA_INV_HI, 8'h80);
    cmd(OP_MRW, 3'h0, 5'h00, MA_CFG, 8'h40);
    e_pat = 16'h275A;
    e_inv = 16'h8001;
    e_dmi = 1'b1;
    cmd(OP_CAL, 3'h0, 5'h00, 6'h00, 8'h00);
    cmd(OP_ACT, 3'h3, 5'h15, 6'h00, 8'h00);
    stat(32'h0000_FF00, 32'h0000_0800);
    check({bank_open, last_bank, last_row}, {8'h08, 3'h3, 5'h15});
    cmd(OP_PRE, 3'h3, 5'h00, 6'h00, 8'h00);
    for (int b = 0; b < NBANK; b++) begin
      cmd(OP_ACT, b[2:0], 5'h15 ^ b[4:0], 6'h00, 8'h00);
    end
    stat(32'h0000_FF00, 32'h0000_FF00);
    check({last_bank, last_row}, {3'h7, 5'h12});
    cmd(OP_RD, 3'h0, 5'h00, 6'h00, 8'h00);
    cmd(OP_RD, 3'h1, 5'h00, 6'h00, 8'h00);
    cmd(OP_WR, 3'h2, 5'h00, 6'h00, 8'h00);
    cmd(OP_RD, 3'h2, 5'h00, 6'h00, 8'h00);
    cmd(OP_PRE, 3'h0, 5'h00, 6'h00, 8'h00);
    cmd(OP_PRE, 3'h2, 5'h00, 6'h00, 8'h00);
    stat(32'h0000_FF00, 32'h0000_FA00);
    check(bank_open, 8'hFA);
    cmd(OP_PER_BANK_REFRESH, 3'h0, 5'h00, 6'h00, 8'h00);
    cmd(OP_PREA, 3'h0, 5'h00, 6'h00, 8'h00);
    cmd(OP_SRE, 3'h0, 5'h00, 6'h00, 8'h00);
    stat(32'h0300_FF00, 32'h0100_0000);
    cmd(OP_SRX, 3'h0, 5'h00, 6'h00, 8'h00);
    cmd(OP_PDE, 3'h0, 5'h00, 6'h00, 8'h00);
    stat(32'h0300_0000, 32'h0200_0000);
    cmd(OP_PDX, 3'h0, 5'h00, 6'h00, 8'h00);
    cmd(OP_ACT, 3'h5, 5'h1F, 6'h00, 8'h00);
    stat(32'h0300_FF00, 32'h0000_2000);
    check(bank_open, 8'h20);
    cmd(OP_RD, 3'h5, 5'h00, 6'h00, 8'h00);
    give_verdict();
  end
endmodule : testbench
